// file: src/host_byte_port_pkg.sv
// Package for the asynchronous host byte port.
// Assumes a single 100 MHz processor clock domain.
package host_byte_port_pkg;

  localparam int unsigned DATA_W        = 8;
  localparam int unsigned SYNC_STAGES   = 3;

  // Processor clock period and host timing, in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned MIN_PULSE_PS  = 15000;
  localparam int unsigned MIN_PULSE_CYC =
    (MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Latency from synchronised access end to flag update, in cycles
  localparam int unsigned FLAG_LAT_CYC  = 1;

  typedef enum logic [0:0] {
    STYLE_SEPARATE = 1'b0,
    STYLE_STROBE   = 1'b1
  } port_style_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } access_state_t;

  typedef struct packed {
    logic chip_select_n;
    logic read_strobe_n;
    logic write_or_direction_n;
  } host_ctrl_t;

  localparam host_ctrl_t CTRL_IDLE = 3'h7;

endpackage : host_byte_port_pkg

// file: src/host_byte_port.sv
// Function
// (RULE1) Asynchronous 8-bit host port, separate-strobe or data-strobe style selectable.
// (RULE2) Separate style: read active while select and read strobe low; later fall.
// (RULE3) Separate style: read ends at first rise of select or read strobe.
// (RULE4) Separate style: write active while select and write strobe low; later fall.
// (RULE5) Separate style: write ends at first rise; data captured then.
// (RULE6) Host holds each separate-style read active at least 1.5 clock periods.
// (RULE7) Host holds each separate-style write active at least 1.5 clock periods.
// (RULE8) Host presents write data 1.5 periods before write end.
// (RULE9) Data-strobe style: read-strobe pin is the single strobe for both directions.
// (RULE10) Data-strobe style: write pin low selects write, high selects read.
// (RULE11) Data-strobe write needs select and strobe low; starts at later fall.
// (RULE12) Data-strobe write ends once select or strobe deasserts.
// (RULE13) Host sets direction one period before the strobe falls.
// (RULE14) Host holds direction stable until the strobe has risen.
// (RULE15) Host select encloses the data strobe.
// (RULE16) Host holds data strobe low at least 1.5 periods.
// (RULE17) Output-empty flag updates within one period after last datum read; code updates it four to five periods after the host ends the read.
// (RULE18) Input-full flag updates within one period after last space written; code updates it four to five periods after the host ends the write.
// (RULE19) Host select and strobes synchronised through flip-flops before edge detection.
// Holds the whole host port; the output and input FIFOs sit outside and talk by
// valid/ready handshakes in the processor clock domain.
`timescale 1ns/1ps
module host_byte_port (
  // Clock and reset
  input  wire logic                                      clock_in,
  input  wire logic                                      rst_n_in,
  // Configuration
  input  wire host_byte_port_pkg::port_style_t           style_in,
  // Host pins
  input  wire logic                                      host_chip_select_n_in,
  input  wire logic                                      host_read_strobe_n_in,
  input  wire logic                                      host_write_or_direction_n_in,
  input  wire logic [host_byte_port_pkg::DATA_W-1:0]     host_data_in,
  output logic      [host_byte_port_pkg::DATA_W-1:0]     host_data_out,
  output logic                                           host_data_oe_out,
  output logic                                           host_out_buffer_empty_out,
  output logic                                           host_in_buffer_full_out,
  // Output FIFO side (device to host)
  input  wire logic [host_byte_port_pkg::DATA_W-1:0]     out_fifo_data_in,
  input  wire logic                                      out_fifo_valid_in,
  input  wire logic                                      out_fifo_last_in,
  output logic                                           out_fifo_pop_out,
  // Input FIFO side (host to device)
  output logic      [host_byte_port_pkg::DATA_W-1:0]     in_fifo_data_out,
  output logic                                           in_fifo_push_out,
  input  wire logic                                      in_fifo_last_space_in,
  input  wire logic                                      in_fifo_full_in
);

  localparam int unsigned N = host_byte_port_pkg::SYNC_STAGES;

  host_byte_port_pkg::host_ctrl_t   raw_ctrl;
  host_byte_port_pkg::host_ctrl_t   sync_r [N];
  host_byte_port_pkg::host_ctrl_t   ctrl_q;
  host_byte_port_pkg::access_state_t state_r;
  host_byte_port_pkg::access_state_t state_nxt;
  logic [host_byte_port_pkg::DATA_W-1:0] data_sync1_r;
  logic [host_byte_port_pkg::DATA_W-1:0] data_sync2_r;
  logic [host_byte_port_pkg::DATA_W-1:0] wdata_r;
  logic                             wr_view;
  logic                             stable;
  logic                             active;
  logic                             is_write;
  logic                             read_end;
  logic                             write_end;

  assign raw_ctrl = '{chip_select_n:        host_chip_select_n_in,
                      read_strobe_n:        host_read_strobe_n_in,
                      write_or_direction_n: host_write_or_direction_n_in};

  // Three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < N; i++) begin
        sync_r[i] <= host_byte_port_pkg::CTRL_IDLE;
      end
    end else begin
      sync_r[0] <= raw_ctrl; // see RULE19
      for (int i = 1; i < N; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= host_byte_port_pkg::CTRL_IDLE;
    end else if (stable) begin
      ctrl_q <= sync_r[1]; // see RULE19
    end
  end

  assign stable = (sync_r[1] == sync_r[2]);

  // Write data is held stable by the host well before the end of the access
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_sync1_r <= 8'h00;
      data_sync2_r <= 8'h00;
    end else begin
      data_sync1_r <= host_data_in;
      data_sync2_r <= data_sync1_r; // see RULE8
    end
  end

  // Write view of the second control stage, aligned with the second data stage;
  // the host may drop the data just after the end, so keep the last open sample
  always_comb begin
    if (style_in == host_byte_port_pkg::STYLE_SEPARATE) begin
      wr_view = !sync_r[1].chip_select_n && !sync_r[1].write_or_direction_n; // see RULE4
    end else begin
      wr_view = !sync_r[1].chip_select_n && !sync_r[1].read_strobe_n &&
                !sync_r[1].write_or_direction_n; // see RULE11
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdata_r <= 8'h00;
    end else if (wr_view) begin
      wdata_r <= data_sync2_r; // see RULE5
    end
  end

  // Access decode per style
  always_comb begin
    if (style_in == host_byte_port_pkg::STYLE_SEPARATE) begin
      active   = !ctrl_q.chip_select_n &&
                 (!ctrl_q.read_strobe_n || !ctrl_q.write_or_direction_n); // see RULE2
      is_write = !ctrl_q.write_or_direction_n; // see RULE4
    end else begin
      active   = !ctrl_q.chip_select_n && !ctrl_q.read_strobe_n; // see RULE9
      is_write = !ctrl_q.write_or_direction_n; // see RULE10
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      host_byte_port_pkg::ST_IDLE: begin
        if (active) begin
          state_nxt = is_write ? host_byte_port_pkg::ST_WRITE
                               : host_byte_port_pkg::ST_READ; // see RULE11
        end
      end
      host_byte_port_pkg::ST_READ: begin
        if (!active) begin
          state_nxt = host_byte_port_pkg::ST_IDLE; // see RULE3
        end
      end
      host_byte_port_pkg::ST_WRITE: begin
        if (!active) begin
          state_nxt = host_byte_port_pkg::ST_IDLE; // see RULE5 RULE12
        end
      end
      default: state_nxt = host_byte_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= host_byte_port_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign read_end  = (state_r == host_byte_port_pkg::ST_READ)  && !active;
  assign write_end = (state_r == host_byte_port_pkg::ST_WRITE) && !active;

  // Read data driven for the whole read access
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_data_out    <= 8'h00;
      host_data_oe_out <= 1'b0;
    end else begin
      host_data_oe_out <= (state_nxt == host_byte_port_pkg::ST_READ); // see RULE1
      if (state_r == host_byte_port_pkg::ST_IDLE && active && !is_write) begin
        host_data_out <= out_fifo_data_in;
      end
    end
  end

  assign out_fifo_pop_out = read_end && out_fifo_valid_in; // see RULE3

  // Capture on the end of the write; a full FIFO drops the byte
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_fifo_data_out <= 8'h00;
      in_fifo_push_out <= 1'b0;
    end else begin
      in_fifo_push_out <= write_end && !in_fifo_full_in; // see RULE5
      if (write_end) begin
        in_fifo_data_out <= wdata_r;
      end
    end
  end

  // Status flags, updated the cycle after the access end is seen
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_out_buffer_empty_out <= 1'b1;
      host_in_buffer_full_out   <= 1'b0;
    end else begin
      if (read_end && out_fifo_last_in) begin
        host_out_buffer_empty_out <= 1'b1; // see RULE17
      end else if (!read_end) begin
        host_out_buffer_empty_out <= !out_fifo_valid_in;
      end
      if (write_end && in_fifo_last_space_in) begin
        host_in_buffer_full_out <= 1'b1; // see RULE18
      end else if (!write_end) begin
        host_in_buffer_full_out <= in_fifo_full_in;
      end
    end
  end

  a_read_empty_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE17
    read_end && out_fifo_last_in |=> host_out_buffer_empty_out)
    else $error("empty flag not raised after last read");

  a_write_full_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE18
    write_end && in_fifo_last_space_in |=> host_in_buffer_full_out)
    else $error("full flag not raised after last write");

  a_write_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE5
    write_end && !in_fifo_full_in |=> in_fifo_push_out && in_fifo_data_out == $past(wdata_r))
    else $error("write not captured at access end");

  a_no_push_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE4
    in_fifo_push_out |-> $past(state_r) == host_byte_port_pkg::ST_WRITE)
    else $error("push without write access");

  a_pop_read_end: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE3
    out_fifo_pop_out |-> state_r == host_byte_port_pkg::ST_READ &&
      (ctrl_q.chip_select_n || ctrl_q.read_strobe_n))
    else $error("pop outside read end");

  a_read_drive: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE2
    state_r == host_byte_port_pkg::ST_READ |-> host_data_oe_out)
    else $error("data not driven during read");

  a_strobe_dir: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE10
    state_r == host_byte_port_pkg::ST_IDLE && active && !is_write
      |=> state_r == host_byte_port_pkg::ST_READ)
    else $error("direction select misread");

  a_sync_stable: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see RULE19
    $changed(ctrl_q) |-> $past(sync_r[1]) == $past(sync_r[2]))
    else $error("control changed without stage agreement");

endmodule : host_byte_port

// file: dv/host_model.sv
// Host processor model driving the byte port pins.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module host_model (
  // Clock and mode
  input  wire logic       clock_in,
  input  wire logic       style_in,
  // Host pins
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic [7:0]      data_out
);
  initial begin
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    data_out = 8'h00;
  end

  // Opens an access and keeps it low for hold cycles
  task automatic start(input logic wr, input logic [7:0] d, input int hold);
    data_out = d;
    if (style_in) begin
      wr_n_out = ~wr;
      @(posedge clock_in);
      #1;
      {cs_n_out, rd_n_out} = 2'h0;
    end else begin
      cs_n_out = 1'b0;
      @(posedge clock_in);
      #1;
      if (wr) wr_n_out = 1'b0;
      else rd_n_out = 1'b0;
    end
    repeat (hold) @(posedge clock_in);
    #1;
  endtask : start

  task automatic finish();
    if (style_in) rd_n_out = 1'b1;
    else {rd_n_out, wr_n_out} = 2'h3;
    @(posedge clock_in);
    #1;
    {cs_n_out, wr_n_out} = 2'h3;
    data_out = ~data_out; // Released bus no longer shows the byte
  endtask : finish
endmodule : host_model

// file: dv/host_byte_port_test.sv
// Testbench for the host byte port: host model on the pins, FIFO side driven here.
// Assumes the design's own assertions judge the fine flag timing.
`timescale 1ns/1ps
module host_byte_port_test;
  logic       clock_in, rst_n_in, cs_n, rd_n, wr_n, oe, empty, full;
  logic       ofv, ofl, pop, push, ils, ifull, full_seen;
  logic [7:0] hdata, dout, ofd, ifd, last_push;
  host_byte_port_pkg::port_style_t style;
  int         fails, checks, cyc, pushes, pops, n;

  host_model host_model_inst (.clock_in(clock_in), .style_in(style), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(hdata));
  host_byte_port host_byte_port_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .style_in(style), .host_chip_select_n_in(cs_n), .host_read_strobe_n_in(rd_n),
    .host_write_or_direction_n_in(wr_n), .host_data_in(hdata), .host_data_out(dout),
    .host_data_oe_out(oe), .host_out_buffer_empty_out(empty),
    .host_in_buffer_full_out(full), .out_fifo_data_in(ofd), .out_fifo_valid_in(ofv),
    .out_fifo_last_in(ofl), .out_fifo_pop_out(pop), .in_fifo_data_out(ifd),
    .in_fifo_push_out(push), .in_fifo_last_space_in(ils), .in_fifo_full_in(ifull));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cyc++;
    if (push === 1'b1) begin
      pushes++;
      last_push = ifd;
      full_seen = full;
    end
    if (pop === 1'b1) pops++;
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask : tick

  task automatic wr_test(input logic [7:0] d, input int hold, input int exp_push);
    n = pushes;
    host_model_inst.start(1'b1, d, hold);
    chk(8'(pushes - n), 8'h00, "push before end");
    host_model_inst.finish();
    tick(8);
    chk(8'(pushes - n), 8'(exp_push), "push count");
    if (exp_push != 0) chk(last_push, d, "write byte");
    if (exp_push != 0) chk(8'(full_seen), 8'(ils), "full at push");
  endtask : wr_test

  task automatic rd_test(input logic [7:0] d, input logic last);
    {ofv, ofl, ofd} = {1'b1, last, d};
    n = pops;
    host_model_inst.start(1'b0, 8'h00, 6);
    chk(8'(oe), 8'h01, "drive enable");
    chk(dout, d, "read byte");
    chk(8'(pops), 8'(n), "pop before end");
    host_model_inst.finish();
    for (int i = 0; i < 8 && pop !== 1'b1; i++) tick(1);
    tick(1);
    chk(8'(empty), 8'(last), "empty at read end");
    if (last) ofv = 1'b0;
    tick(2);
    chk(8'(pops - n), 8'h01, "pop count");
    chk(8'(oe), 8'h00, "drive released");
    chk(8'(empty), 8'(last), "empty flag");
  endtask : rd_test

  task automatic t_separate();
    style = host_byte_port_pkg::STYLE_SEPARATE;
    ils = 1'b1;
    wr_test(8'h3C, 6, 1);
    ifull = 1'b1;
    ils = 1'b0;
    tick(1);
    chk(8'(full), 8'h01, "full flag");
    wr_test(8'h55, 2, 0);
    ifull = 1'b0;
    tick(4);
    chk(8'(full), 8'h00, "full cleared");
    rd_test(8'hA5, 1'b1);
    $display("test separate done");
  endtask : t_separate

  task automatic t_strobe();
    style = host_byte_port_pkg::STYLE_STROBE;
    tick(4);
    wr_test(8'hC3, 2, 1);
    rd_test(8'h5A, 1'b0);
    rd_test(8'h81, 1'b1);
    $display("test strobe done");
  endtask : t_strobe

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  initial begin
    {rst_n_in, ofv, ofl, ils, ifull} = 5'h0;
    ofd = 8'h00;
    style = host_byte_port_pkg::STYLE_SEPARATE;
    repeat (10) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    tick(2);
    chk(8'({empty, full, oe}), 8'h04, "reset flags");
    t_separate();
    t_strobe();
    stop_test();
  end
endmodule : host_byte_port_test
